// File: core/ramp_pulse_gen.sv
// Table-driven ramp pulse generator, first channel, with APB registers.
// Assumes exec and interrupt pins are asynchronous; APB is on clk.
`timescale 1ns/1ps
module ramp_pulse_gen #(
  parameter int CycPerMs = ramp_pkg::CYC_PER_MS // Clock cycles per ms
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        execIn,
  input  wire logic        intIn,
  input  wire logic        pulseBAux,
  output logic             firstPulseOutput,
  output logic             secondPulseOutput,
  output logic             directionOutputOne,
  output logic             chanTwoBlocked
);
  import ramp_pkg::*;

  typedef enum logic [2:0] {
    stIdle, stLoad, stRampFirst, stSteady, stHold, stRampLast
  } state_t;

  // Step parameter check, returns an error code
  function automatic logic [3:0] chkStep(input logic [31:0] f,
      input logic [31:0] r, input logic [31:0] p, input logic [31:0] o,
      input logic rng);
    logic [31:0] fMin;
    fMin = rng ? FREQ1_MIN : FREQ0_MIN;
    if (p == 32'h0 || p > PRESET_MAX) return ERR_PRESET;
    if (f < fMin || f > FREQ_MAX) return ERR_FREQ;
    if (r < RAMP_MIN || r > RAMP_MAX) return ERR_RAMP;
    if (o[31:7] != 25'h0) return ERR_OPTS;
    if (o[6:2] > STEP_MAX) return ERR_NEXT;
    return ERR_NONE;
  endfunction : chkStep

  // Frequency in Hz from table units
  function automatic logic [16:0] toHz(input logic [13:0] f,
      input logic rng);
    return rng ? 17'(f * HZ_MUL1) : {3'h0, f};
  endfunction : toHz

  logic [31:0] tbl [MAX_STEPS*TBL_WORDS];  // Step table
  ctrl_t       ctrl_q;                     // Software control
  ctrl_t       cfg_q;                      // Control latched at start
  state_t      state_q;                    // Sequencer state
  logic [4:0]  curStep_q;                  // Running step number
  logic [13:0] curF_q;                     // Output frequency, units
  logic [13:0] tgtF_q;                     // Steady frequency, units
  logic [13:0] rampDiff_q;                 // Ramp span, units
  logic [31:0] rampN_q;                    // Ramp length, cycles
  logic [31:0] rampErr_q;                  // Ramp error accumulator
  logic [26:0] preset_q;                   // Pulse target
  logic [26:0] cnt_q;                      // Pulses of this step
  opts_t       opts_q;                     // Latched step options
  logic        complete_q;                 // Completion flag
  logic        overflow_q;                 // Pulses beyond target
  logic [3:0]  err_q;                      // Last error code
  logic [31:0] accum_q;                    // Phase accumulator
  logic        msbPrev_q;                  // Previous accumulator MSB
  logic [2:0]  execSync_q;                 // Exec synchroniser
  logic [2:0]  intSync_q;                  // Interrupt synchroniser
  logic        execLvl_q;                  // Filtered exec level
  logic        intLvl_q;                   // Filtered interrupt level
  logic        pulseDir_q;                 // Direction of the live pulse

  // Pin edges, accepted once second and third stages agree
  wire execAgree = execSync_q[1] == execSync_q[2];
  wire intAgree  = intSync_q[1] == intSync_q[2];
  wire execRise  = execAgree & execSync_q[2] & ~execLvl_q;
  wire execFall  = execAgree & ~execSync_q[2] & execLvl_q;
  wire intRise   = intAgree & intSync_q[2] & ~intLvl_q;

  // Status decode
  wire running   = state_q != stIdle;
  wire rampAct   = state_q == stRampFirst || state_q == stRampLast;
  wire ramping   = rampAct && curF_q != tgtF_q;
  wire dual      = cfg_q.dirMode == DIR_DUAL;
  wire hitPreset = cnt_q == preset_q;

  // Step table fetch for the step being loaded
  wire [6:0]  tIdx   = 7'({curStep_q - 5'h1, 2'h0});
  wire [31:0] wFreq  = tbl[tIdx | 7'(W_FREQ)];
  wire [31:0] wRamp  = tbl[tIdx | 7'(W_RAMP)];
  wire [31:0] wPre   = tbl[tIdx | 7'(W_PRESET)];
  wire [31:0] wOpts  = tbl[tIdx | 7'(W_OPTS)];
  wire        badNo  = curStep_q == 5'h0 || curStep_q > cfg_q.numSteps;
  wire [3:0]  chkErr = chkStep(wFreq, wRamp, wPre, wOpts, cfg_q.range);
  wire [3:0]  loadErr = badNo ? ERR_NEXT : chkErr;
  wire [13:0] newF   = wFreq[13:0];
  wire [13:0] newDiff = newF > curF_q ? newF - curF_q : curF_q - newF;
  wire [13:0] rampMs = wRamp[13:0] - 14'(wRamp[13:0] % 14'(RAMP_UNIT_MS));
  wire [13:0] minF   = ctrl_q.range ? FREQ1_MIN[13:0] : FREQ0_MIN[13:0];
  wire        intBad = ctrl_q.intStep == 5'h0 ||
                       ctrl_q.intStep > cfg_q.numSteps;

  // Linear ramp: Bresenham spread of the span over the ramp cycles
  wire [32:0] rampSum  = {1'b0, rampErr_q} + {19'h0, rampDiff_q};
  wire        rampStep = ramping && rampSum >= {1'b0, rampN_q};

  // Phase increment from the current frequency
  wire [33:0] incProd  = 34'(toHz(curF_q, cfg_q.range)) * DDS_MUL;
  wire [31:0] phaseInc = 32'(incProd >> DDS_SHIFT);
  wire        pulseLvl = running & accum_q[31];
  wire        pulseRise = pulseLvl & ~msbPrev_q;

  // APB decode
  wire setup   = psel & ~penable;
  wire access  = psel & penable & pready;
  wire inTbl   = paddr >= A_TBL && paddr < A_TBLEND && paddr[1:0] == 2'h0;
  wire hit     = paddr == A_CTRL || paddr == A_STATUS ||
                 paddr == A_COUNT || paddr == A_FREQ || inTbl;
  wire [11:0] tOff = paddr - A_TBL;
  wire [6:0]  wIdx = tOff[8:2];
  status_t stat;
  assign stat = '{err: err_q, step: curStep_q, dir: opts_q.dir,
                  overflow: overflow_q, ramping: ramping,
                  complete: complete_q, running: running};
  wire [31:0] rdMux = paddr == A_CTRL   ? {14'h0, ctrl_q} :
                      paddr == A_STATUS ? {18'h0, stat} :
                      paddr == A_COUNT  ? {5'h0, cnt_q} :
                      paddr == A_FREQ   ? {18'h0, curF_q} :
                      inTbl             ? tbl[wIdx] : 32'h0;

  // Pin synchronisers and filtered levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      execSync_q <= 3'h0;
      intSync_q  <= 3'h0;
      execLvl_q  <= 1'b0;
      intLvl_q   <= 1'b0;
    end else begin
      execSync_q <= {execSync_q[1:0], execIn};
      intSync_q  <= {intSync_q[1:0], intIn};
      if (execAgree) execLvl_q <= execSync_q[2];
      if (intAgree) intLvl_q <= intSync_q[2];
    end
  end

  // APB answer: one wait-free access phase after each setup
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      prdata  <= (setup & ~pwrite) ? rdMux : 32'h0;
    end
  end

  // Register and table writes; status words are read only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      for (int i = 0; i < MAX_STEPS*TBL_WORDS; i++) tbl[i] <= 32'h0;
    end else if (access && pwrite) begin
      if (paddr == A_CTRL) ctrl_q <= pwdata[17:0];
      else if (inTbl) tbl[wIdx] <= pwdata;
    end
  end

  // Step sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= stIdle;
      cfg_q      <= CTRL_RST;
      curStep_q  <= 5'h0;
      tgtF_q     <= 14'h0;
      rampDiff_q <= 14'h0;
      rampN_q    <= 32'h0;
      preset_q   <= 27'h0;
      opts_q     <= '0;
      complete_q <= 1'b0;
      err_q      <= ERR_NONE;
    end else if (execFall) begin
      state_q <= stIdle;
    end else if (execRise) begin
      state_q    <= stLoad;
      cfg_q      <= ctrl_q;
      curStep_q  <= ctrl_q.startStep;
      complete_q <= 1'b0;
      err_q      <= ERR_NONE;
    end else if (intRise && running) begin
      if (intBad) begin
        state_q <= stIdle;
        err_q   <= ERR_INT;
      end else begin
        state_q   <= stLoad;
        curStep_q <= ctrl_q.intStep;
      end
    end else begin
      unique case (state_q)
        stIdle: ;
        stLoad: begin
          if (loadErr != ERR_NONE) begin
            state_q <= stIdle;
            err_q   <= loadErr;
          end else begin
            tgtF_q     <= newF;
            rampDiff_q <= newDiff;
            rampN_q    <= 32'(rampMs) * 32'(CycPerMs);
            preset_q   <= wPre[26:0];
            opts_q     <= wOpts[6:0];
            state_q    <= wOpts[1] ? stHold : stRampFirst;
          end
        end
        stRampFirst: begin
          if (hitPreset) state_q <= stLoad;
          else if (curF_q == tgtF_q) state_q <= stSteady;
        end
        stSteady: if (hitPreset) state_q <= stLoad;
        stHold: if (hitPreset) state_q <= stRampLast;
        stRampLast: if (curF_q == tgtF_q) state_q <= stLoad;
      endcase
      // Completion: chain or stop
      if ((state_q == stRampFirst || state_q == stSteady) && hitPreset ||
          state_q == stRampLast && curF_q == tgtF_q) begin
        if (opts_q.next == 5'h0) begin
          state_q    <= stIdle;
          complete_q <= 1'b1;
        end else begin
          curStep_q <= opts_q.next;
        end
      end
    end
  end

  // Frequency ramp engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      curF_q    <= 14'h0;
      rampErr_q <= 32'h0;
    end else if (execRise) begin
      curF_q    <= minF;
      rampErr_q <= 32'h0;
    end else if (state_q == stLoad) begin
      rampErr_q <= 32'h0;
    end else if (ramping) begin
      if (rampStep) begin
        curF_q    <= tgtF_q > curF_q ? curF_q + 14'h1 : curF_q - 14'h1;
        rampErr_q <= 32'(rampSum - {1'b0, rampN_q});
      end else begin
        rampErr_q <= rampSum[31:0];
      end
    end
  end

  // Phase accumulator and pulse counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      accum_q    <= 32'h0;
      msbPrev_q  <= 1'b0;
      cnt_q      <= 27'h0;
      overflow_q <= 1'b0;
    end else begin
      accum_q   <= running ? accum_q + phaseInc : 32'h0;
      msbPrev_q <= accum_q[31];
      if (state_q == stLoad || execRise) begin
        cnt_q      <= 27'h0;
        overflow_q <= 1'b0;
      end else if (pulseRise) begin
        if (hitPreset) overflow_q <= 1'b1;
        else cnt_q <= cnt_q + 27'h1;
      end
    end
  end

  // Direction of the pulse on the lines; it only follows the step while
  // the pulse level is low, so a step change never splits one pulse
  // across the forward and reverse lines
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulseDir_q <= 1'b0;
    end else if (!pulseLvl) begin
      pulseDir_q <= opts_q.dir;
    end
  end

  // Pin outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      firstPulseOutput   <= 1'b0;
      secondPulseOutput  <= 1'b0;
      directionOutputOne <= 1'b0;
      chanTwoBlocked     <= 1'b0;
    end else begin
      firstPulseOutput   <= pulseLvl & ~(dual & pulseDir_q);
      secondPulseOutput  <= dual ? pulseLvl & pulseDir_q : pulseBAux;
      directionOutputOne <= cfg_q.dirMode == DIR_LEVEL & opts_q.dir;
      chanTwoBlocked     <= ctrl_q.dirMode == DIR_DUAL;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  range0_a: assert property (running && state_q != stLoad && !cfg_q.range
    |-> curF_q >= 14'h1 && curF_q <= 14'h2710)
    else $error("mode 0 frequency out of range");
  range1_a: assert property (running && state_q != stLoad && cfg_q.range
    |-> curF_q >= 14'h14 && curF_q <= 14'h2710)
    else $error("mode 1 frequency out of range");
  start_step_a: assert property (execRise |=> state_q == stLoad &&
    curStep_q == $past(ctrl_q.startStep))
    else $error("start did not load start step");
  int_jump_a: assert property (intRise && running && !execFall &&
    !execRise && !intBad |=> curStep_q == $past(ctrl_q.intStep))
    else $error("interrupt did not jump");
  exec_stop_a: assert property (execFall |=> !running ##1 !pulseLvl)
    else $error("exec fall did not stop");
  count_cap_a: assert property (running |-> cnt_q <= preset_q ||
    state_q == stLoad)
    else $error("count beyond target");
  dual_pulse_a: assert property ($rose(secondPulseOutput) && $past(dual)
    |-> $past(pulseDir_q))
    else $error("forward pulse on reverse output");
  // Second line carries the other channel unless dual mode owns it
  second_aux_a: assert property (!dual |=>
    secondPulseOutput == $past(pulseBAux))
    else $error("second line not passed through");
  dual_block_a: assert property (ctrl_q.dirMode == DIR_DUAL |=>
    chanTwoBlocked)
    else $error("second channel not blocked");
  // Steady phase only once the target frequency is reached
  steady_flag_a: assert property (state_q == stSteady |->
    curF_q == tgtF_q && !ramping)
    else $error("steady phase off target");
  complete_idle_a: assert property (complete_q |-> !running)
    else $error("complete while running");
  dir_level_a: assert property (cfg_q.dirMode == DIR_LEVEL && running
    ##1 $stable(opts_q.dir) |-> directionOutputOne == opts_q.dir)
    else $error("direction level wrong");
  dir_off_a: assert property (cfg_q.dirMode == DIR_OFF |=>
    !directionOutputOne)
    else $error("direction driven while off");
  stop_zero_a: assert property (state_q == stSteady && hitPreset &&
    opts_q.next == 5'h0 && !execFall && !execRise && !intRise
    |=> !running && complete_q)
    else $error("zero next step did not stop");

  ramp_first_c: cover property (state_q == stRampFirst ##1
    state_q == stSteady);
  ramp_last_c: cover property (state_q == stHold ##1
    state_q == stRampLast);
  jump_c: cover property (intRise && running);
  overflow_c: cover property ($rose(overflow_q));
endmodule : ramp_pulse_gen

// File: core/ramp_pkg.sv
// Shared constants, field layouts and types of the ramp pulse generator.
// Assumes a 125 MHz system clock and a 32-bit APB register bus.
package ramp_pkg;
  localparam int CLK_HZ       = 125_000_000;      // System clock rate
  localparam int MS_PER_S     = 1000;             // Milliseconds per second
  localparam int CYC_PER_MS   = CLK_HZ / MS_PER_S; // Cycles in one ms
  localparam int RAMP_UNIT_MS = 10;               // Ramp time granularity
  localparam int MAX_STEPS    = 18;               // Table depth
  localparam int TBL_WORDS    = 4;                // Words per step
  // Limits of the step fields
  localparam logic [31:0] FREQ_MAX   = 32'h0000_2710; // 10000 units
  localparam logic [31:0] FREQ0_MIN  = 32'h0000_0001; // 1 Hz units
  localparam logic [31:0] FREQ1_MIN  = 32'h0000_0014; // 20 x 10 Hz
  localparam logic [31:0] RAMP_MIN   = 32'h0000_000A; // 10 ms
  localparam logic [31:0] RAMP_MAX   = 32'h0000_2710; // 10000 ms
  localparam logic [31:0] PRESET_MAX = 32'h05F5_E100; // 100,000,000
  localparam logic [4:0]  STEP_MAX   = 5'h12;         // 18
  localparam logic [16:0] HZ_MUL1    = 17'h0000A;     // Mode 1 unit 10 Hz
  // Phase step per Hz: 2^32 / CLK_HZ as 35184 / 2^10
  localparam logic [33:0] DDS_MUL    = 34'h0_0000_8970;
  localparam int          DDS_SHIFT  = 10;
  // Byte addresses
  localparam logic [11:0] A_CTRL   = 12'h000;
  localparam logic [11:0] A_STATUS = 12'h004;
  localparam logic [11:0] A_COUNT  = 12'h008;
  localparam logic [11:0] A_FREQ   = 12'h00C;
  localparam logic [11:0] A_TBL    = 12'h100;
  localparam logic [11:0] A_TBLEND = 12'h220;
  // Table word order inside a step
  localparam logic [1:0] W_FREQ = 2'h0;
  localparam logic [1:0] W_RAMP = 2'h1;
  localparam logic [1:0] W_PRESET = 2'h2;
  localparam logic [1:0] W_OPTS = 2'h3;
  // Error codes
  localparam logic [3:0] ERR_NONE   = 4'h0;
  localparam logic [3:0] ERR_PRESET = 4'h3;
  localparam logic [3:0] ERR_FREQ   = 4'h4;
  localparam logic [3:0] ERR_RAMP   = 4'h5;
  localparam logic [3:0] ERR_OPTS   = 4'h7;
  localparam logic [3:0] ERR_NEXT   = 4'h8;
  localparam logic [3:0] ERR_INT    = 4'h9;
  // Direction modes
  localparam logic [1:0] DIR_OFF   = 2'h0;
  localparam logic [1:0] DIR_LEVEL = 2'h1;
  localparam logic [1:0] DIR_DUAL  = 2'h2;
  typedef struct packed {
    logic [4:0] intStep;   // Interrupt step
    logic [4:0] startStep; // Start step
    logic [4:0] numSteps;  // Steps in use
    logic [1:0] dirMode;   // Direction mode
    logic       range;     // Frequency range mode
  } ctrl_t;
  localparam logic [17:0] CTRL_RST = 18'h02108; // 1,1,1,off,mode 0
  typedef struct packed {
    logic [3:0] err;
    logic [4:0] step;
    logic       dir;
    logic       overflow;
    logic       ramping;
    logic       complete;
    logic       running;
  } status_t;
  typedef struct packed {
    logic [4:0] next;      // Next step, 0 ends
    logic       rampLast;  // Ramp after the steady phase
    logic       dir;       // Reverse when set
  } opts_t;
endpackage : ramp_pkg

// File: test/motor_drive_model.sv
// Motor drive pulse input model: counts steps on both pulse lines.
// Assumes the pulse and direction lines are registered on clk.
`timescale 1ns/1ps
module motor_drive_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic stepFwd,   // Forward or single pulse line
  input  wire logic stepRev,   // Reverse pulse line
  input  wire logic dirLevel,  // Direction level line
  output int        fwdCount,  // Rising edges on stepFwd
  output int        revCount,  // Rising edges on stepRev
  output int        fwdPeriod, // Cycles between the last two fwd edges
  output logic      dirAtStep  // Direction level at the last fwd edge
);
  logic fwdPrev_q;             // Last fwd line level
  logic revPrev_q;             // Last rev line level
  int   sinceEdge;             // Cycles since the last fwd edge
  // Edge counters, period and direction capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fwdPrev_q <= 1'b0;
      revPrev_q <= 1'b0;
      sinceEdge <= 0;
      fwdCount  <= 0;
      revCount  <= 0;
      fwdPeriod <= 0;
      dirAtStep <= 1'b0;
    end else begin
      fwdPrev_q <= stepFwd;
      revPrev_q <= stepRev;
      sinceEdge <= sinceEdge + 1;
      if (stepFwd && !fwdPrev_q) begin
        fwdCount  <= fwdCount + 1;
        fwdPeriod <= sinceEdge + 1;
        sinceEdge <= 0;
        dirAtStep <= dirLevel;
      end
      if (stepRev && !revPrev_q) begin
        revCount <= revCount + 1;
      end
    end
  end
endmodule : motor_drive_model

// File: test/test_ramp_pulse_gen.sv
// Testbench of the ramp pulse generator: APB tasks and step sequences.
// Assumes ramp_pkg, ramp_pulse_gen and motor_drive_model are compiled.
`timescale 1ns/1ps
module test_multi_step_ramp_pulse_generator;
  import ramp_pkg::*;
  localparam int PER50K = CLK_HZ / 50000; // Cycles per 50 kHz pulse
  logic        clk, rst_n, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, rdErr, rampSeen;
  logic        execIn, intIn, pulseBAux, dirAtStep;
  logic        firstPulseOutput, secondPulseOutput;
  logic        directionOutputOne, chanTwoBlocked;
  int          fwdCount, revCount, fwdPeriod, f0, r0;
  int          err_total, samples_checked;
  // Design under test with short milliseconds
  ramp_pulse_gen #(.CycPerMs(500)) u_dut (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .execIn(execIn), .intIn(intIn),
    .pulseBAux(pulseBAux), .firstPulseOutput(firstPulseOutput),
    .secondPulseOutput(secondPulseOutput),
    .directionOutputOne(directionOutputOne),
    .chanTwoBlocked(chanTwoBlocked));
  // Far side drive model
  motor_drive_model u_drive (.clk(clk), .rst_n(rst_n),
    .stepFwd(firstPulseOutput), .stepRev(secondPulseOutput),
    .dirLevel(directionOutputOne), .fwdCount(fwdCount),
    .revCount(revCount), .fwdPeriod(fwdPeriod), .dirAtStep(dirAtStep));
  // Clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Counts and verdict
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; data and error are taken at the ready edge
  task automatic apb(input logic isWr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= isWr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) begin
        err_total++;
        end_of_test();
      end
    end while (pready !== 1'b1);
    rd    = prdata;
    rdErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Read and compare
  task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdChk
  // Fill the four words of one step
  task automatic setStep(input int s, input logic [31:0] f, r, p,
                         input opts_t o);
    logic [11:0] b;
    b = A_TBL + 12'(16 * (s - 1));
    apb(1'b1, b, f);
    apb(1'b1, b + 12'h4, r);
    apb(1'b1, b + 12'h8, p);
    apb(1'b1, b + 12'hC, {25'h0, o});
  endtask : setStep
  // Control word: range 1, two steps, interrupt step 2
  task automatic setCtrl(input logic [1:0] dm, input logic [4:0] st);
    ctrl_t c;
    c = ctrl_t'{5'h2, st, 5'h2, dm, 1'b1};
    apb(1'b1, A_CTRL, {14'h0, c});
  endtask : setCtrl
  // Raise exec and let the pin filter pass it
  task automatic startRun();
    @(posedge clk);
    execIn <= 1'b1;
    repeat (8) @(posedge clk);
    f0 = fwdCount;
    r0 = revCount;
  endtask : startRun
  // Drop exec and wait for the filter
  task automatic stopRun();
    @(posedge clk);
    execIn <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : stopRun
  // Poll status until emission ends, noting any ramp
  task automatic waitIdle();
    int n;
    n = 0;
    rampSeen = 1'b0;
    do begin
      apb(1'b0, A_STATUS, 32'h0);
      if (rd[2] === 1'b1) rampSeen = 1'b1;
      n++;
      if (n > 9000) begin
        err_total++;
        end_of_test();
      end
    end while (rd[0] !== 1'b0);
  endtask : waitIdle
  // Hang guard
  initial begin
    #790_000;
    err_total++;
    end_of_test();
  end
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, execIn, intIn, pulseBAux} = 7'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    err_total = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, last table word, unmapped place
    rdChk(A_CTRL, {14'h0, CTRL_RST});
    rdChk(A_STATUS, 32'h0);
    apb(1'b1, 12'h21C, 32'h4);
    rdChk(12'h21C, 32'h4);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, rdErr}, 32'h1);
    // Level mode: ramp-first chain 1 -> 2 -> end
    setStep(1, 32'h1388, 32'hA, 32'h4, opts_t'{5'h2, 1'b0, 1'b0});
    setStep(2, 32'h1388, 32'h14, 32'h3, opts_t'{5'h0, 1'b0, 1'b1});
    setCtrl(DIR_LEVEL, 5'h1);
    startRun();
    apb(1'b0, A_STATUS, 32'h0);
    chk({27'h0, rd[9:5]}, 32'h1);
    chk({31'h0, rd[0]}, 32'h1);
    waitIdle();
    chk({30'h0, rd[1:0]}, 32'h2);
    chk(32'(fwdCount - f0), 32'h7);
    chk(32'(revCount - r0), 32'h0);
    chk({31'h0, dirAtStep}, 32'h1);
    chk({31'h0, rampSeen}, 32'h1);
    chk(32'(fwdPeriod >= PER50K - PER50K / 20 &&
            fwdPeriod <= PER50K + PER50K / 20), 32'h1);
    stopRun();
    // Dual mode: forward step on first line, reverse on second
    setCtrl(DIR_DUAL, 5'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, chanTwoBlocked}, 32'h1);
    startRun();
    waitIdle();
    chk(32'(fwdCount - f0), 32'h4);
    chk(32'(revCount - r0), 32'h3);
    stopRun();
    // Direction off: one line only, second line free for aux
    setCtrl(DIR_OFF, 5'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, chanTwoBlocked}, 32'h0);
    startRun();
    waitIdle();
    chk(32'(fwdCount - f0), 32'h7);
    chk(32'(revCount - r0), 32'h0);
    stopRun();
    pulseBAux <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk({31'h0, secondPulseOutput}, 32'h1);
    chk({31'h0, directionOutputOne}, 32'h0);
    @(posedge clk);
    pulseBAux <= 1'b0;
    // Long step: interrupt jump, exec fall, restart
    setStep(1, 32'h2710, 32'hA, 32'h3E8, opts_t'{5'h0, 1'b0, 1'b0});
    setCtrl(DIR_LEVEL, 5'h1);
    startRun();
    repeat (3000) @(posedge clk);
    intIn <= 1'b1;
    repeat (8) @(posedge clk);
    apb(1'b0, A_STATUS, 32'h0);
    chk({27'h0, rd[9:5]}, 32'h2);
    intIn <= 1'b0;
    stopRun();
    apb(1'b0, A_STATUS, 32'h0);
    chk({31'h0, rd[0]}, 32'h0);
    f0 = fwdCount;
    repeat (2000) @(posedge clk);
    chk(32'(fwdCount - f0), 32'h0);
    startRun();
    rdChk(A_COUNT, 32'h0);
    apb(1'b0, A_STATUS, 32'h0);
    chk({27'h0, rd[9:5]}, 32'h1);
    stopRun();
    // Frequency one below the mode 1 floor is refused
    apb(1'b1, A_TBL, 32'h13);
    startRun();
    apb(1'b0, A_STATUS, 32'h0);
    chk({28'h0, rd[13:10]}, {28'h0, ERR_FREQ});
    chk({31'h0, rd[0]}, 32'h0);
    stopRun();
    end_of_test();
  end
endmodule : test_multi_step_ramp_pulse_generator
